// ### src/modulator_carrier_select.sv
// Purpose: Carrier selection and mixing of the data signal modulator, AXI4-Lite registers
// Assumes: All inputs synchronous to i_ref_clk; i_rst synchronous, active high
// Notes: Carrier registers have no reset so their contents survive i_rst
`timescale 1ns/1ps
`include "carrier_defs.svh"
module modulator_carrier_select
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic [`ADDR_W-1:0]  i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  output carrier_pkg::axi_resp_t   o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  input  wire logic [`ADDR_W-1:0]  i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  output logic [31:0]              o_rdata,
  output carrier_pkg::axi_resp_t   o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  input  wire logic                i_modulator,
  input  wire logic                i_carrier_pin_one,
  input  wire logic                i_carrier_pin_two,
  input  wire logic                i_ref_carrier,
  input  wire logic [3:0]          i_pwm_unit_out,
  output logic                     o_mixed,
  output logic [3:0]               o_pwm_drive_disable
);
  import carrier_pkg::*;

  // Returns one-hot {status, modulator control, low carrier, high carrier}
  function automatic logic [3:0] decode(input logic [`ADDR_W-1:0] a);
    decode = {a[`ADDR_W-1:2] == `STATUS_IDX, a[`ADDR_W-1:2] == `MOD_CTRL_IDX,
              a[`ADDR_W-1:2] == `LOW_CTRL_IDX, a[`ADDR_W-1:2] == `HIGH_CTRL_IDX};
  endfunction

  function automatic logic pwm_hit(input logic [3:0] sel, input logic [1:0] k);
    pwm_hit = (sel[3:2] == `PWM_GROUP) && (sel[1:0] == k);
  endfunction

  // Register state
  logic [7:0]         high_carrier_control;
  logic [7:0]         low_carrier_control;
  logic               modulator_enable;
  logic [7:0]         next_high_carrier_control;
  logic [7:0]         next_low_carrier_control;
  logic               next_modulator_enable;

  // Bus state
  logic               aw_got;
  logic               w_got;
  logic [`ADDR_W-1:0] aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               next_aw_got;
  logic               next_w_got;
  logic [`ADDR_W-1:0] next_aw_addr;
  logic [31:0]        next_w_data;
  logic [3:0]         next_w_strb;
  logic               next_awready;
  logic               next_wready;
  logic               next_bvalid;
  axi_resp_t          next_bresp;
  logic               next_arready;
  logic               next_rvalid;
  logic [31:0]        next_rdata;
  axi_resp_t          next_rresp;

  logic               aw_fire;
  logic               w_fire;
  logic               ar_fire;
  logic               do_write;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic [3:0]         wr_hit;
  logic [3:0]         rd_hit;

  // Mixing state
  mix_state_t         state;
  mix_state_t         next_state;
  logic               high_carrier;
  logic               low_carrier;
  logic               high_prev;
  logic               low_prev;
  logic               high_fall;
  logic               low_fall;
  logic               next_mixed;
  logic [3:0]         next_drive_disable;

  logic [3:0]         high_sel;
  logic [3:0]         low_sel;
  logic               high_sync;
  logic               low_sync;

  carrier_src_if src ();

  assign src.pin_one = i_carrier_pin_one;
  assign src.pin_two = i_carrier_pin_two;
  assign src.ref_clk = i_ref_carrier;
  assign src.pwm     = i_pwm_unit_out;

  assign high_sel  = high_carrier_control[`SEL_MSB:`SEL_LSB];
  assign low_sel   = low_carrier_control[`SEL_MSB:`SEL_LSB];
  assign high_sync = high_carrier_control[`SYNC_BIT];
  assign low_sync  = low_carrier_control[`SYNC_BIT];

  carrier_conditioner high_path
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .src       (src),
    .i_select  (high_sel),
    .i_invert  (high_carrier_control[`INV_BIT]),
    .o_carrier (high_carrier)
  );

  carrier_conditioner low_path
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .src       (src),
    .i_select  (low_sel),
    .i_invert  (low_carrier_control[`INV_BIT]),
    .o_carrier (low_carrier)
  );

  // Register bus: address and data taken in either order, response after both
  always_comb
  begin
    aw_fire  = i_awvalid && o_awready;
    w_fire   = i_wvalid && o_wready;
    ar_fire  = i_arvalid && o_arready;
    wr_addr  = aw_fire ? i_awaddr : aw_addr;
    wr_data  = w_fire ? i_wdata : w_data;
    wr_strb  = w_fire ? i_wstrb : w_strb;
    do_write = (aw_got || aw_fire) && (w_got || w_fire);
    wr_hit   = do_write ? decode(wr_addr) : 4'h0;
    rd_hit   = decode(i_araddr);

    next_aw_addr = aw_fire ? i_awaddr : aw_addr;
    next_w_data  = w_fire ? i_wdata : w_data;
    next_w_strb  = w_fire ? i_wstrb : w_strb;
    next_aw_got  = (aw_got || aw_fire) && !do_write;
    next_w_got   = (w_got || w_fire) && !do_write;
    next_bvalid  = do_write || (o_bvalid && !i_bready);
    next_bresp   = o_bresp;
    if (do_write)
      next_bresp = (wr_hit == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;

    // Only bit 0 lane is meaningful; bit 4 never stores
    next_high_carrier_control = high_carrier_control;
    next_low_carrier_control  = low_carrier_control;
    next_modulator_enable     = modulator_enable;
    if (wr_hit[0] && wr_strb[0])
      next_high_carrier_control = wr_data[7:0] & `CTRL_WMASK; // RULE_09
    if (wr_hit[1] && wr_strb[0])
      next_low_carrier_control = wr_data[7:0] & `CTRL_WMASK; // RULE_09
    if (wr_hit[2] && wr_strb[0])
      next_modulator_enable = wr_data[`ENABLE_BIT];

    next_rvalid  = ar_fire || (o_rvalid && !i_rready);
    next_arready = !next_rvalid;
    next_rdata   = o_rdata;
    next_rresp   = o_rresp;
    if (ar_fire)
    begin
      next_rresp = (rd_hit == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (rd_hit[0])
        next_rdata = {24'h00_0000, high_carrier_control & `CTRL_WMASK}; // RULE_09
      if (rd_hit[1])
        next_rdata = {24'h00_0000, low_carrier_control & `CTRL_WMASK}; // RULE_09
      if (rd_hit[2])
        next_rdata = {31'h0000_0000, modulator_enable};
      if (rd_hit[3])
        next_rdata = {29'h0000_0000, state == ST_HOLD_HIGH || state == ST_HOLD_LOW,
                      state == ST_HIGH || state == ST_HOLD_HIGH, o_mixed};
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      aw_got           <= 1'b0;
      w_got            <= 1'b0;
      aw_addr          <= '0;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      o_awready        <= 1'b0;
      o_wready         <= 1'b0;
      o_bvalid         <= 1'b0;
      o_bresp          <= `RESP_OKAY;
      o_arready        <= 1'b0;
      o_rvalid         <= 1'b0;
      o_rdata          <= 32'h0000_0000;
      o_rresp          <= `RESP_OKAY;
      modulator_enable <= 1'b0;
    end
    else
    begin
      aw_got           <= next_aw_got;
      w_got            <= next_w_got;
      aw_addr          <= next_aw_addr;
      w_data           <= next_w_data;
      w_strb           <= next_w_strb;
      o_awready        <= next_awready;
      o_wready         <= next_wready;
      o_bvalid         <= next_bvalid;
      o_bresp          <= next_bresp;
      o_arready        <= next_arready;
      o_rvalid         <= next_rvalid;
      o_rdata          <= next_rdata;
      o_rresp          <= next_rresp;
      modulator_enable <= next_modulator_enable;
    end
  end

  // Carrier selections are left untouched by reset
  always_ff @(posedge i_ref_clk)
  begin
    high_carrier_control <= next_high_carrier_control; // RULE_10
    low_carrier_control  <= next_low_carrier_control; // RULE_10
  end

  // Mixer: selections stay in their registers while disabled
  always_comb
  begin
    high_fall  = high_prev && !high_carrier;
    low_fall   = low_prev && !low_carrier;
    next_state = state;
    unique case (state)
      ST_OFF:
        next_state = i_modulator ? ST_HIGH : ST_LOW; // RULE_11
      ST_HIGH:
        if (!i_modulator)
          next_state = (high_sync && !high_fall) ? ST_HOLD_HIGH : ST_LOW; // RULE_05
      ST_HOLD_HIGH:
        if (i_modulator)
          next_state = ST_HIGH;
        else if (high_fall)
          next_state = ST_LOW; // RULE_05
      ST_LOW:
        if (i_modulator)
          next_state = (low_sync && !low_fall) ? ST_HOLD_LOW : ST_HIGH; // RULE_06
      ST_HOLD_LOW:
        if (!i_modulator)
          next_state = ST_LOW;
        else if (low_fall)
          next_state = ST_HIGH; // RULE_06
      default:
        next_state = ST_OFF;
    endcase
    if (!modulator_enable)
      next_state = ST_OFF; // RULE_11
    next_mixed = 1'b0;
    if (next_state == ST_HIGH || next_state == ST_HOLD_HIGH)
      next_mixed = high_carrier; // RULE_12
    else if (next_state == ST_LOW || next_state == ST_HOLD_LOW)
      next_mixed = low_carrier; // RULE_12
  end

  // Pin release of the PWM unit picked by either channel
  for (genvar k = 0; k < 4; k++)
  begin : g_drive
    assign next_drive_disable[k] = modulator_enable &&
      ((high_carrier_control[`ODIS_BIT] && pwm_hit(high_sel, 2'(k))) || // RULE_07
       (low_carrier_control[`ODIS_BIT] && pwm_hit(low_sel, 2'(k)))); // RULE_08
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state               <= ST_OFF;
      high_prev           <= 1'b0;
      low_prev            <= 1'b0;
      o_mixed             <= 1'b0;
      o_pwm_drive_disable <= 4'h0;
    end
    else
    begin
      state               <= next_state;
      high_prev           <= high_carrier;
      low_prev            <= low_carrier;
      o_mixed             <= next_mixed;
      o_pwm_drive_disable <= next_drive_disable;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  hold_high_a: assert property ((modulator_enable && state == ST_HIGH && !i_modulator && high_sync && !high_fall)
    |=> state == ST_HOLD_HIGH) // RULE_05
    else $error("high sync did not hold the switch");
  switch_high_a: assert property ((modulator_enable && state == ST_HIGH && !i_modulator && !high_sync)
    |=> state == ST_LOW && o_mixed == $past(low_carrier)) // RULE_05
    else $error("unsynced high switch not immediate");
  hold_low_a: assert property ((modulator_enable && state == ST_LOW && i_modulator && low_sync && !low_fall)
    |=> state == ST_HOLD_LOW ##1 (state != ST_HIGH || $past(low_fall) || !$past(i_modulator))) // RULE_06
    else $error("low sync did not hold the switch");
  release_low_a: assert property ((modulator_enable && state == ST_HOLD_LOW && i_modulator && low_fall)
    |=> state == ST_HIGH) // RULE_06
    else $error("low falling edge did not release");
  mix_high_a: assert property ((modulator_enable && state == ST_HIGH && i_modulator)
    |=> o_mixed == $past(high_carrier)) // RULE_12
    else $error("mixed output not the high carrier");
  mix_low_a: assert property ((modulator_enable && state == ST_LOW && !i_modulator) // RULE_12
    |=> o_mixed == $past(low_carrier))
    else $error("mixed output not the low carrier");
  switch_low_a: assert property ((modulator_enable && state == ST_LOW && i_modulator && !low_sync) // RULE_06
    |=> state == ST_HIGH && o_mixed == $past(high_carrier))
    else $error("unsynced low switch not immediate");
  release_high_a: assert property ((modulator_enable && state == ST_HOLD_HIGH && !i_modulator && high_fall) // RULE_05
    |=> state == ST_LOW && o_mixed == $past(low_carrier))
    else $error("high falling edge did not release");
  off_quiet_a: assert property (!modulator_enable |=> !o_mixed && state == ST_OFF) // RULE_11
    else $error("disabled mixer still drives");
  reenable_a: assert property ((state == ST_OFF && modulator_enable && i_modulator)
    |=> state == ST_HIGH && $stable(high_carrier_control)) // RULE_11
    else $error("enable did not reapply the high carrier");
  high_pin_a: assert property ((modulator_enable && high_carrier_control[`ODIS_BIT] && high_sel == `SRC_PWM_BASE)
    |=> o_pwm_drive_disable[0]) // RULE_07
    else $error("high source pin not released");
  low_pin_a: assert property ((modulator_enable && low_carrier_control[`ODIS_BIT] && low_sel == `SRC_PWM_LAST)
    |=> o_pwm_drive_disable[3]) // RULE_08
    else $error("low source pin not released");
  bit4_zero_a: assert property (o_rvalid |-> !o_rdata[`UNUSED_BIT]) // RULE_09
    else $error("unimplemented bit read as one");
endmodule

// ### src/carrier_defs.svh
// Purpose: Register map, field positions and source codes of the carrier selector
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Definitions only
// Notes on behaviour
// [RULE_01] High select bits 3:0 choose ground, pin one, pin two, reference, PWM one to four.
// [RULE_02] Low select uses the same codes; 0110 and 0111 give PWM three and four.
// [RULE_03] High invert bit 6 inverts the selected high carrier before mixing.
// [RULE_04] Low invert bit 6 inverts the selected low carrier before mixing.
// [RULE_05] High sync bit 5 holds a high-to-low switch until a high carrier falling edge.
// [RULE_06] Low sync bit 5 holds a low-to-high switch until a low carrier falling edge.
// [RULE_07] High pin-disable bit 7 stops the chosen high source driving its own pin.
// [RULE_08] Low pin-disable bit 7 stops the chosen low source driving its own pin.
// [RULE_09] Bit 4 of both carrier registers ignores writes and reads zero.
// [RULE_10] Carrier registers power up undefined and keep their contents over other resets.
// [RULE_11] Clearing enable keeps all selections; setting it again reapplies them.
// [RULE_12] Mixed output follows high carrier while modulator is one, low carrier otherwise.
`ifndef CARRIER_DEFS_SVH
`define CARRIER_DEFS_SVH

`define ADDR_W          8
`define HIGH_CTRL_IDX   6'h00
`define LOW_CTRL_IDX    6'h01
`define MOD_CTRL_IDX    6'h02
`define STATUS_IDX      6'h03

`define SEL_MSB         3
`define SEL_LSB         0
`define UNUSED_BIT      4
`define SYNC_BIT        5
`define INV_BIT         6
`define ODIS_BIT        7
`define CTRL_WMASK      8'hEF
`define ENABLE_BIT      0

`define SRC_GROUND      4'h0
`define SRC_PIN_ONE     4'h1
`define SRC_PIN_TWO     4'h2
`define SRC_REF_CLK     4'h3
`define SRC_PWM_BASE    4'h4
`define SRC_PWM_LAST    4'h7
`define PWM_GROUP       2'h1

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### src/carrier_pkg.sv
// Purpose: Shared types of the carrier selector
// Assumes: Nothing beyond the defines header
// Notes: State codes are one-hot
package carrier_pkg;
  typedef logic [1:0] axi_resp_t;

  typedef enum logic [4:0] {
    ST_OFF       = 5'h01,
    ST_HIGH      = 5'h02,
    ST_LOW       = 5'h04,
    ST_HOLD_HIGH = 5'h08,
    ST_HOLD_LOW  = 5'h10
  } mix_state_t;
endpackage

// ### src/carrier_src_if.sv
// Purpose: Bundle of candidate carrier sources
// Assumes: All sources synchronous to the register clock
// Notes: One bundle feeds both carrier channels
`timescale 1ns/1ps
interface carrier_src_if;
  logic       pin_one;
  logic       pin_two;
  logic       ref_clk;
  logic [3:0] pwm;

  modport provider (output pin_one, output pin_two, output ref_clk, output pwm);
  modport consumer (input pin_one, input pin_two, input ref_clk, input pwm);
endinterface

// ### src/carrier_conditioner.sv
// Purpose: Select and optionally invert one carrier source
// Assumes: Select and invert come from a software register
// Notes: Output is registered, one cycle behind the sources
`timescale 1ns/1ps
`include "carrier_defs.svh"
module carrier_conditioner
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  carrier_src_if.consumer src,
  input  wire logic [3:0] i_select,
  input  wire logic       i_invert,
  output logic            o_carrier
);
  import carrier_pkg::*;

  logic picked;
  logic next_carrier;

  always_comb
  begin
    picked = 1'b0;
    if (i_select[3:2] == `PWM_GROUP)
    begin
      picked = src.pwm[i_select[1:0]]; // RULE_01 RULE_02
    end
    else if (i_select == `SRC_PIN_ONE)
    begin
      picked = src.pin_one; // RULE_01
    end
    else if (i_select == `SRC_PIN_TWO)
    begin
      picked = src.pin_two; // RULE_01
    end
    else if (i_select == `SRC_REF_CLK)
    begin
      picked = src.ref_clk; // RULE_01
    end
    next_carrier = picked ^ i_invert; // RULE_03 RULE_04
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_carrier <= 1'b0;
    else
      o_carrier <= next_carrier;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  ground_select_a: assert property ((i_select == `SRC_GROUND) |=> o_carrier == $past(i_invert)) // RULE_01
    else $error("ground source not constant");
  reserved_select_a: assert property (i_select[3] |=> o_carrier == $past(i_invert)) // RULE_02
    else $error("reserved code connected a source");
  invert_path_a: assert property ((i_select == `SRC_PIN_ONE) |=> o_carrier == ($past(src.pin_one) ^ $past(i_invert))) // RULE_03
    else $error("pin one not passed with polarity");
  pwm_path_a: assert property ((i_select == `SRC_PWM_LAST) |=> o_carrier == ($past(src.pwm[3]) ^ $past(i_invert))) // RULE_04
    else $error("pwm four not passed with polarity");
endmodule

// ### verification/carrier_source_model.sv
// Purpose: Model of the pins, reference carrier and PWM units feeding the selector
// Assumes: Sources change just after the rising clock edge
// Notes: The reference carrier runs with period 8 while spinning
`timescale 1ns/1ps
module carrier_source_model
(
  input  wire logic       i_ref_clk,
  input  wire logic [6:0] i_level,
  input  wire logic       i_spin,
  input  wire logic [3:0] i_drive_disable,
  output logic            o_pin_one,
  output logic            o_pin_two,
  output logic            o_ref_carrier,
  output logic [3:0]      o_pwm,
  output logic [3:0]      o_pwm_pin
);
  logic [2:0] phase = 3'h0;

  always_ff @(posedge i_ref_clk)
  begin
    phase         <= phase + 3'h1;
    o_pin_one     <= i_level[0];
    o_pin_two     <= i_level[1];
    o_ref_carrier <= i_spin ? phase[2] : i_level[2];
    o_pwm         <= i_level[6:3];
  end

  // A unit that loses its pin drive leaves the pin low
  assign o_pwm_pin = o_pwm & ~i_drive_disable;
endmodule

// ### verification/modulator_carrier_select_test.sv
// Purpose: Self-checking bench of the carrier selector over AXI4-Lite
// Assumes: Byte addresses 0x00, 0x04, 0x08, 0x0C as set by the designer
// Notes: Carrier path is 1 cycle in the model plus 2 in the selector
`timescale 1ns/1ps
`include "carrier_defs.svh"
module modulator_carrier_select_test;
  import carrier_pkg::*;
  localparam logic [7:0] A_HIGH = {`HIGH_CTRL_IDX, 2'h0};
  localparam logic [7:0] A_LOW  = {`LOW_CTRL_IDX, 2'h0};
  localparam logic [7:0] A_MOD  = {`MOD_CTRL_IDX, 2'h0};
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, modulator, spin;
  logic        awready, wready, bvalid, arready, rvalid, mixed;
  logic        pin_one, pin_two, ref_carrier;
  logic [7:0]  awaddr, araddr, ctl, src;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, pwm, pwm_pin, drive_disable;
  logic [6:0]  level;
  axi_resp_t   bresp, rresp, resp;
  logic        exp_bit;
  int          err_total, samples_checked, ch, code, inv, pat, sync, k;
  logic [7:0]  hi_t[4]  = '{8'h84, 8'h05, 8'h8f, 8'h85};
  logic [7:0]  lo_t[4]  = '{8'h87, 8'h87, 8'h8a, 8'h81};
  logic [3:0]  dis_t[4] = '{4'h9, 4'h8, 4'h0, 4'h2};

  modulator_carrier_select dut
  (
    .i_ref_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_modulator(modulator), .i_carrier_pin_one(pin_one), .i_carrier_pin_two(pin_two),
    .i_ref_carrier(ref_carrier), .i_pwm_unit_out(pwm), .o_mixed(mixed),
    .o_pwm_drive_disable(drive_disable)
  );

  carrier_source_model far_side
  (
    .i_ref_clk(clk), .i_level(level), .i_spin(spin), .i_drive_disable(drive_disable),
    .o_pin_one(pin_one), .o_pin_two(pin_two), .o_ref_carrier(ref_carrier), .o_pwm(pwm),
    .o_pwm_pin(pwm_pin)
  );

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stall();
    err_total++;
    $display("MISMATCH at %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'h0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= {24'h00_0000, d};
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bready && bvalid)
      begin
        resp = bresp;
        bready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) stall();
  endtask

  task automatic rdr(input logic [7:0] a);
    logic done;
    done = 1'h0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rready && rvalid)
      begin
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) stall();
  endtask

  task automatic wait_mixed(input logic v);
    for (int n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (mixed === v) return;
    end
    stall();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial
  begin
    rst = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready, modulator, spin} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    level = 7'h00;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    settle(1);
    check(drive_disable, 4'h0);
    wr(A_HIGH, 8'hff);
    rdr(A_HIGH);
    check(rd, 32'h0000_00ef);
    wr(A_LOW, 8'h10);
    rdr(A_LOW);
    check(rd, 32'h0000_0000);
    wr(8'h10, 8'h01);
    check(resp, `RESP_SLVERR);
    rdr(8'h10);
    check(rd, 32'h0000_0000);
    check(resp, `RESP_SLVERR);
    $display("test registers done");
    wr(A_MOD, 8'h01);
    for (ch = 0; ch < 2; ch++)
      for (code = 0; code < 16; code++)
        for (inv = 0; inv < 2; inv++)
          for (pat = 0; pat < 2; pat++)
          begin
            exp_bit = ((code >= 1 && code <= 7) ? !pat[0] : 1'h0) ^ inv[0];
            ctl = {1'h0, inv[0], 2'h0, code[3:0]};
            wr(ch ? A_LOW : A_HIGH, ctl);
            wr(ch ? A_HIGH : A_LOW, {1'h0, !exp_bit, 6'h00});
            src = 8'h01 << code;
            if (pat) src = ~src;
            level <= src[7:1];
            modulator <= !ch[0];
            settle(5);
            check(mixed, exp_bit);
          end
    $display("test source select done");
    for (k = 0; k < 4; k++)
    begin
      wr(A_HIGH, hi_t[k]);
      level <= 7'h7f;
      wr(A_LOW, lo_t[k]);
      settle(3);
      check(drive_disable, dis_t[k]);
      check(pwm_pin, 4'(~dis_t[k]));
    end
    wr(A_MOD, 8'h00);
    modulator <= 1'h1;
    settle(3);
    check({mixed, drive_disable}, 5'h00);
    rdr(A_HIGH);
    check(rd, 32'h0000_0085);
    wr(A_MOD, 8'h01);
    settle(3);
    check(drive_disable, 4'h2);
    $display("test pin disable and enable done");
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdr(A_HIGH);
    check(rd, 32'h0000_0085);
    rdr(A_LOW);
    check(rd, 32'h0000_0081);
    rdr(A_MOD);
    check(rd, 32'h0000_0000);
    $display("test reset retention done");
    wr(A_MOD, 8'h01);
    level <= 7'h00;
    for (ch = 0; ch < 2; ch++)
      for (sync = 0; sync < 2; sync++)
      begin
        wr(A_HIGH, ch ? 8'h00 : {2'h0, sync[0], 5'h03});
        wr(A_LOW, ch ? {2'h0, sync[0], 5'h03} : 8'h00);
        spin <= 1'h1;
        modulator <= !ch[0];
        wait_mixed(1'h1);
        wait_mixed(1'h0);
        wait_mixed(1'h1);
        modulator <= ch[0];
        settle(1);
        check(mixed, sync[0]);
        wait_mixed(1'h0);
        spin <= 1'h0;
      end
    $display("test carrier sync done");
    test_done();
  end
endmodule
